// File: ccr_pkg.sv
`default_nettype none
package ccr_pkg;
	// ****************************************
	// Register map and reset values
	// ****************************************
	localparam logic [7:0] ADDR_CURRENTS = 8'h03;
	localparam logic [7:0] ADDR_VOLTAGE = 8'h04;
	localparam logic [7:0] ADDR_TERM_TIMER = 8'h05;
	localparam logic [7:0] ADDR_INPUT_PROT = 8'h06;
	localparam logic [7:0] RST_CURRENTS = 8'h22;
	localparam logic [7:0] RST_VOLTAGE = 8'h58;
	localparam logic [7:0] RST_TERM_TIMER = 8'h9F;
	localparam logic [7:0] RST_INPUT_PROT = 8'h66;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int PRECHG_LSB = 4;
	localparam int TERM_CUR_LSB = 0;
	localparam int CHGV_LSB = 3;
	localparam int TOPOFF_LSB = 1;
	localparam int RECHG_BIT = 0;
	localparam int TERM_EN_BIT = 7;
	localparam int WDOG_LSB = 4;
	localparam int TMR_EN_BIT = 3;
	localparam int TMR_DUR_BIT = 2;
	localparam int OVP_LSB = 6;
	localparam int BOOSTV_LSB = 4;
	localparam int VINLIM_LSB = 0;

	// ****************************************
	// Clamps and field encodings
	// ****************************************
	localparam logic [3:0] PRECHG_MAX_CODE = 4'hC;
	localparam logic [4:0] CHGV_MAX_CODE = 5'h18;
	localparam logic [4:0] CHGV_SPECIAL_CODE = 5'h0F;
	localparam int CUR_STEP_MA = 60;
	localparam int CUR_OFFSET_MA = 60;
	localparam int CHGV_STEP_MV = 32;
	localparam int CHGV_OFFSET_MV = 3856;
	localparam int CHGV_SPECIAL_MV = 4352;
	localparam int VINLIM_STEP_MV = 100;
	localparam int VINLIM_OFFSET_MV = 3900;
	localparam int OVP0_MV = 5500;
	localparam int OVP1_MV = 6500;
	localparam int OVP2_MV = 10500;
	localparam int OVP3_MV = 14000;
	localparam int TOPOFF_STEP_MIN = 15;
	localparam int SAFETY_SHORT_H = 5;
	localparam int SAFETY_LONG_H = 10;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ = 40_000_000;
	localparam int SECOND_S = 1;
	localparam int SECOND_CYCLES = SECOND_S * CLK_HZ;
	localparam int WDOG_BASE_S = 40;

	// Arbitrary bus address, no meaning beyond this design.
	localparam logic [6:0] I2C_ADDR = 7'h5A;
endpackage
`default_nettype wire

// File: ccr_i2c_slave.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_i2c_slave (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic wr_stb,
	output logic [7:0] ptr,
	output logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	typedef enum logic [2:0] {
		CCR_IDLE = 3'b000,
		CCR_ADDR = 3'b001,
		CCR_ACK_A = 3'b010,
		CCR_WRITE = 3'b011,
		CCR_ACK_W = 3'b100,
		CCR_READ = 3'b101,
		CCR_ACK_R = 3'b110
	} ccr_i2c_state_t;

	ccr_i2c_state_t state;
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic scl_q;
	logic sda_q;
	logic [7:0] sh;
	logic [7:0] tx;
	logic [3:0] bitcnt;
	logic first_byte;
	logic is_read;
	logic master_ack;

	// ****************************************
	// Pin synchronisers and bus events
	// ****************************************
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			scl_sync <= 2'b11;
			sda_sync <= 2'b11;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (ce) begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			scl_q <= scl_sync[1];
			sda_q <= sda_sync[1];
		end
	end

	wire scl_s = scl_sync[1];
	wire sda_s = sda_sync[1];
	wire start_ev = scl_s & scl_q & sda_q & ~sda_s;
	wire stop_ev = scl_s & scl_q & ~sda_q & sda_s;
	wire scl_rise = scl_s & ~scl_q;
	wire scl_fall = ~scl_s & scl_q;
	wire addr_hit = (sh[7:1] == ccr_pkg::I2C_ADDR);

	// ****************************************
	// Byte engine
	// ****************************************
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state <= CCR_IDLE;
			sh <= 8'h00;
			tx <= 8'h00;
			bitcnt <= 4'h0;
			first_byte <= 1'b0;
			is_read <= 1'b0;
			master_ack <= 1'b0;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			wr_stb <= 1'b0;
			ptr <= 8'h00;
			wdata <= 8'h00;
		end else if (ce) begin
			wr_stb <= 1'b0;
			if (start_ev) begin
				state <= CCR_ADDR;
				bitcnt <= 4'h0;
				first_byte <= 1'b1;
				sda_oe <= 1'b0;
			end else if (stop_ev) begin
				state <= CCR_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (state)
					CCR_ADDR, CCR_WRITE: begin
						if (scl_rise) begin
							sh <= {sh[6:0], sda_s};
							bitcnt <= bitcnt + 4'h1;
						end else if (scl_fall && bitcnt == 4'h8) begin
							if (state == CCR_ADDR) begin
								is_read <= sh[0];
								state <= addr_hit ? CCR_ACK_A : CCR_IDLE;
								sda_oe <= addr_hit;
							end else begin
								if (first_byte) begin
									ptr <= sh;
								end else begin
									wdata <= sh;
									wr_stb <= 1'b1;
								end
								state <= CCR_ACK_W;
								sda_oe <= 1'b1;
							end
						end
					end
					CCR_ACK_A: begin
						if (scl_fall) begin
							bitcnt <= 4'h0;
							if (is_read) begin
								tx <= rdata;
								sda_oe <= ~rdata[7];
								state <= CCR_READ;
							end else begin
								sda_oe <= 1'b0;
								state <= CCR_WRITE;
							end
						end
					end
					CCR_ACK_W: begin
						if (scl_fall) begin
							if (!first_byte) begin
								ptr <= ptr + 8'h01;
							end
							first_byte <= 1'b0;
							bitcnt <= 4'h0;
							sda_oe <= 1'b0;
							state <= CCR_WRITE;
						end
					end
					CCR_READ: begin
						if (scl_rise) begin
							bitcnt <= bitcnt + 4'h1;
						end else if (scl_fall && bitcnt == 4'h8) begin
							sda_oe <= 1'b0;
							ptr <= ptr + 8'h01;
							state <= CCR_ACK_R;
						end else if (scl_fall) begin
							tx <= {tx[6:0], 1'b0};
							sda_oe <= ~tx[6];
						end
					end
					CCR_ACK_R: begin
						if (scl_rise) begin
							master_ack <= ~sda_s;
						end else if (scl_fall) begin
							// A refused byte ends the read; the pointer already moved on.
							bitcnt <= 4'h0;
							tx <= rdata;
							sda_oe <= master_ack & ~rdata[7];
							state <= master_ack ? CCR_READ : CCR_IDLE;
						end
					end
					default: begin
						sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end
endmodule // ccr_i2c_slave
`default_nettype wire

// File: ccr_config_regs.sv
// Functional notes
// RULE_01 - Precharge code is 60 mA per step plus 60 mA; default 0010; clamp at 1100.
// RULE_02 - Termination code is 60 mA per step plus 60 mA; default 0010.
// RULE_03 - Charge voltage code is 32 mV per step above 3.856 V, up to 11000.
// RULE_04 - Charge voltage writes above 11000 store and read back as 11000.
// RULE_05 - Charge voltage defaults to 01011; code 01111 means 4.352 V.
// RULE_06 - Top-off timer: off by default, else 15, 30 or 45 minutes.
// RULE_07 - Termination enable bit: 0 off, 1 on, default on.
// RULE_08 - Watchdog period: off, 40 s, 80 s or 160 s; default 40 s.
// RULE_09 - One enable bit drives both precharge and fast-charge timers; default on.
// RULE_10 - Safety timer duration bit: 0 gives 5 hours, 1 gives 10 hours.
// RULE_11 - Input overvoltage code selects 5.5, 6.5, 10.5 or 14 V; default 6.5 V.
// RULE_12 - Input voltage limit is 100 mV per step above 3.9 V; default 0110.
// RULE_13 - Registers 3 to 5 reset on register reset or watchdog expiry; 6 only on reset.
// RULE_14 - Watchdog restart bit clears itself once the watchdog has restarted.
`timescale 1ns/1ps
`default_nettype none
module ccr_config_regs #(
	parameter int SECOND_CYCLES = ccr_pkg::SECOND_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic reg_reset,
	input wire logic watchdog_restart_req,
	output logic watchdog_restart_bit,
	output logic watchdog_expired,
	output logic [3:0] precharge_current_code,
	output logic [3:0] termination_current_code,
	output logic [4:0] charge_voltage_code,
	output logic [1:0] topoff_duration,
	output logic termination_enable,
	output logic safety_timer_enable,
	output logic safety_timer_duration,
	output logic [1:0] input_overvoltage_threshold,
	output logic [3:0] input_voltage_limit_code,
	output logic [9:0] precharge_ma,
	output logic [9:0] termination_ma,
	output logic [12:0] charge_mv,
	output logic [5:0] topoff_minutes,
	output logic [3:0] safety_timer_hours,
	output logic [13:0] ovp_mv,
	output logic [12:0] input_limit_mv
);
	logic [7:0] reg_currents;
	logic [7:0] reg_voltage;
	logic [7:0] reg_term_timer;
	logic [7:0] reg_input_prot;
	logic [25:0] sec_cnt;
	logic [7:0] wd_sec;

	wire wr_stb;
	wire [7:0] ptr;
	wire [7:0] wdata;
	wire [7:0] rdata;

	// ****************************************
	// Serial host port
	// ****************************************
	ccr_i2c_slave u_i2c (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.ce(ce),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.wr_stb(wr_stb),
		.ptr(ptr),
		.wdata(wdata),
		.rdata(rdata)
	);

	// ****************************************
	// Address decode and write clamps
	// ****************************************
	wire sel_currents = (ptr == ccr_pkg::ADDR_CURRENTS);
	wire sel_voltage = (ptr == ccr_pkg::ADDR_VOLTAGE);
	wire sel_term_timer = (ptr == ccr_pkg::ADDR_TERM_TIMER);
	wire sel_input_prot = (ptr == ccr_pkg::ADDR_INPUT_PROT);

	assign rdata = sel_currents ? reg_currents :
		sel_voltage ? reg_voltage :
		sel_term_timer ? reg_term_timer :
		sel_input_prot ? reg_input_prot : ccr_pkg::UNMAPPED_READ;

	wire [3:0] wr_prechg = wdata[ccr_pkg::PRECHG_LSB +: 4];
	wire [4:0] wr_chgv = wdata[ccr_pkg::CHGV_LSB +: 5];
	// Clamping at write time means software reads back what the loop really uses.
	wire [3:0] clamp_prechg = (wr_prechg > ccr_pkg::PRECHG_MAX_CODE) ? ccr_pkg::PRECHG_MAX_CODE : wr_prechg; // RULE_01
	wire [4:0] clamp_chgv = (wr_chgv > ccr_pkg::CHGV_MAX_CODE) ? ccr_pkg::CHGV_MAX_CODE : wr_chgv; // RULE_04
	wire [7:0] next_currents = {clamp_prechg, wdata[3:0]}; // RULE_01 RULE_02
	wire [7:0] next_voltage = {clamp_chgv, wdata[2:0]}; // RULE_03 RULE_04

	// ****************************************
	// Host watchdog
	// ****************************************
	wire [1:0] wd_code = reg_term_timer[ccr_pkg::WDOG_LSB +: 2];
	wire [7:0] wd_period_s = (wd_code == 2'b01) ? 8'(ccr_pkg::WDOG_BASE_S) :
		(wd_code == 2'b10) ? 8'(2 * ccr_pkg::WDOG_BASE_S) :
		(wd_code == 2'b11) ? 8'(4 * ccr_pkg::WDOG_BASE_S) : 8'h00; // RULE_08
	wire wd_on = (wd_code != 2'b00); // RULE_08
	wire sec_tick = (sec_cnt == 26'(SECOND_CYCLES - 1));
	// A register reset in the same cycle wins, so no expiry pulse is raised then.
	wire wd_fire = wd_on && sec_tick && (wd_sec == wd_period_s - 8'h01) && !reg_reset; // RULE_13
	// Restart on the cycle the restart bit is seen, so the bit can drop one cycle later.
	wire wd_restart = watchdog_restart_bit || reg_reset || wd_fire || !wd_on;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sec_cnt <= 26'h000_0000;
			wd_sec <= 8'h00;
		end else if (ce) begin
			if (wd_restart) begin
				sec_cnt <= 26'h000_0000;
				wd_sec <= 8'h00;
			end else if (sec_tick) begin
				sec_cnt <= 26'h000_0000;
				wd_sec <= wd_sec + 8'h01;
			end else begin
				sec_cnt <= sec_cnt + 26'h000_0001;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			watchdog_restart_bit <= 1'b0;
			watchdog_expired <= 1'b0;
		end else if (ce) begin
			// A new request in the clearing cycle keeps the bit set.
			watchdog_restart_bit <= watchdog_restart_req; // RULE_14
			watchdog_expired <= wd_fire;
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			reg_currents <= ccr_pkg::RST_CURRENTS;
			reg_voltage <= ccr_pkg::RST_VOLTAGE;
			reg_term_timer <= ccr_pkg::RST_TERM_TIMER;
		end else if (ce) begin
			if (reg_reset || wd_fire) begin
				reg_currents <= ccr_pkg::RST_CURRENTS; // RULE_13 RULE_01 RULE_02
				reg_voltage <= ccr_pkg::RST_VOLTAGE; // RULE_13 RULE_05 RULE_06
				reg_term_timer <= ccr_pkg::RST_TERM_TIMER; // RULE_13 RULE_07 RULE_08 RULE_09 RULE_10
			end else if (wr_stb) begin
				if (sel_currents) begin
					reg_currents <= next_currents;
				end else if (sel_voltage) begin
					reg_voltage <= next_voltage;
				end else if (sel_term_timer) begin
					reg_term_timer <= wdata;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			reg_input_prot <= ccr_pkg::RST_INPUT_PROT;
		end else if (ce) begin
			if (reg_reset) begin
				reg_input_prot <= ccr_pkg::RST_INPUT_PROT; // RULE_13 RULE_11 RULE_12
			end else if (wr_stb && sel_input_prot) begin
				reg_input_prot <= wdata;
			end
		end
	end

	// ****************************************
	// Field outputs
	// ****************************************
	assign precharge_current_code = reg_currents[ccr_pkg::PRECHG_LSB +: 4];
	assign termination_current_code = reg_currents[ccr_pkg::TERM_CUR_LSB +: 4];
	assign charge_voltage_code = reg_voltage[ccr_pkg::CHGV_LSB +: 5];
	assign topoff_duration = reg_voltage[ccr_pkg::TOPOFF_LSB +: 2];
	assign termination_enable = reg_term_timer[ccr_pkg::TERM_EN_BIT]; // RULE_07
	assign safety_timer_enable = reg_term_timer[ccr_pkg::TMR_EN_BIT]; // RULE_09
	assign safety_timer_duration = reg_term_timer[ccr_pkg::TMR_DUR_BIT];
	assign input_overvoltage_threshold = reg_input_prot[ccr_pkg::OVP_LSB +: 2];
	assign input_voltage_limit_code = reg_input_prot[ccr_pkg::VINLIM_LSB +: 4];

	// ****************************************
	// Decoded physical values
	// ****************************************
	wire [9:0] next_precharge_ma =
		10'(ccr_pkg::CUR_OFFSET_MA + ccr_pkg::CUR_STEP_MA * int'(precharge_current_code)); // RULE_01
	wire [9:0] next_termination_ma =
		10'(ccr_pkg::CUR_OFFSET_MA + ccr_pkg::CUR_STEP_MA * int'(termination_current_code)); // RULE_02
	wire [12:0] next_charge_mv = (charge_voltage_code == ccr_pkg::CHGV_SPECIAL_CODE) ?
		13'(ccr_pkg::CHGV_SPECIAL_MV) :
		13'(ccr_pkg::CHGV_OFFSET_MV + ccr_pkg::CHGV_STEP_MV * int'(charge_voltage_code)); // RULE_03 RULE_05
	// A zero here means no top-off: charging stops as soon as termination holds.
	wire [5:0] next_topoff_minutes = 6'(ccr_pkg::TOPOFF_STEP_MIN * int'(topoff_duration)); // RULE_06
	wire [3:0] next_safety_hours = !safety_timer_enable ? 4'h0 :
		safety_timer_duration ? 4'(ccr_pkg::SAFETY_LONG_H) : 4'(ccr_pkg::SAFETY_SHORT_H); // RULE_09 RULE_10
	wire [13:0] next_ovp_mv = (input_overvoltage_threshold == 2'b00) ? 14'(ccr_pkg::OVP0_MV) :
		(input_overvoltage_threshold == 2'b01) ? 14'(ccr_pkg::OVP1_MV) :
		(input_overvoltage_threshold == 2'b10) ? 14'(ccr_pkg::OVP2_MV) : 14'(ccr_pkg::OVP3_MV); // RULE_11
	wire [12:0] next_input_limit_mv =
		13'(ccr_pkg::VINLIM_OFFSET_MV + ccr_pkg::VINLIM_STEP_MV * int'(input_voltage_limit_code)); // RULE_12

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			precharge_ma <= 10'h0B4;
			termination_ma <= 10'h0B4;
			charge_mv <= 13'h1070;
			topoff_minutes <= 6'h00;
			safety_timer_hours <= 4'hA;
			ovp_mv <= 14'h1964;
			input_limit_mv <= 13'h1194;
		end else if (ce) begin
			precharge_ma <= next_precharge_ma;
			termination_ma <= next_termination_ma;
			charge_mv <= next_charge_mv;
			topoff_minutes <= next_topoff_minutes;
			safety_timer_hours <= next_safety_hours;
			ovp_mv <= next_ovp_mv;
			input_limit_mv <= next_input_limit_mv;
		end
	end
endmodule // ccr_config_regs
`default_nettype wire

// File: ccr_config_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_config_monitor #(
	parameter int SECOND_CYCLES = 4
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	input wire logic reg_reset,
	input wire logic watchdog_restart_req,
	input wire logic watchdog_restart_bit,
	input wire logic watchdog_expired,
	input wire logic [3:0] precharge_current_code,
	input wire logic [3:0] termination_current_code,
	input wire logic [4:0] charge_voltage_code,
	input wire logic [1:0] topoff_duration,
	input wire logic termination_enable,
	input wire logic safety_timer_enable,
	input wire logic safety_timer_duration,
	input wire logic [1:0] input_overvoltage_threshold,
	input wire logic [3:0] input_voltage_limit_code,
	input wire logic [9:0] precharge_ma,
	input wire logic [9:0] termination_ma,
	input wire logic [12:0] charge_mv,
	input wire logic [5:0] topoff_minutes,
	input wire logic [3:0] safety_timer_hours,
	input wire logic [13:0] ovp_mv,
	input wire logic [12:0] input_limit_mv
);
	// ****************************************
	// Field and decode checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	sequence s_req_pulse;
		ce && watchdog_restart_req ##1 ce && !watchdog_restart_req;
	endsequence
	sequence s_bit_pulse;
		watchdog_restart_bit ##1 !watchdog_restart_bit;
	endsequence
	a_prechg_clamp: assert property (precharge_current_code <= 4'hC)
		else $error("precharge code above clamp");
	a_charge_voltage_code_clamp: assert property (charge_voltage_code <= 5'h18)
		else $error("charge voltage code above clamp");
	a_current_decode: assert property (ce |=> precharge_ma == $past(precharge_current_code) * 60 + 60
		&& termination_ma == $past(termination_current_code) * 60 + 60) else $error("current decode wrong");
	a_voltage_decode: assert property (ce |=> charge_mv == ($past(charge_voltage_code) == 5'h0F ? 4352
		: 3856 + 32 * $past(charge_voltage_code))) else $error("charge voltage decode wrong");
	a_timer_decode: assert property (ce |=> topoff_minutes == 15 * $past(topoff_duration)
		&& safety_timer_hours == (!$past(safety_timer_enable) ? 0 : $past(safety_timer_duration) ? 10 : 5))
		else $error("timer decode wrong");
	a_input_decode: assert property (ce |=>
		input_limit_mv == 3900 + 100 * $past(input_voltage_limit_code)
		&& ovp_mv == ($past(input_overvoltage_threshold) == 2'h0 ? 5500 : $past(input_overvoltage_threshold) == 2'h1
		? 6500 : $past(input_overvoltage_threshold) == 2'h2 ? 10500 : 14000)) else $error("input decode wrong");
	a_restart_clears: assert property (s_req_pulse |-> s_bit_pulse)
		else $error("restart bit did not pulse");
	a_expiry_defaults: assert property (watchdog_expired |-> precharge_current_code == 4'h2
		&& termination_current_code == 4'h2 && charge_voltage_code == 5'h0B && topoff_duration == 2'h0
		&& termination_enable && safety_timer_enable && safety_timer_duration) else $error("expiry left fields");
	a_expiry_keeps: assert property (watchdog_expired && !$past(reg_reset) |->
		$stable(input_overvoltage_threshold) && $stable(input_voltage_limit_code))
		else $error("expiry changed input fields");
	a_reset_defaults: assert property (ce && reg_reset |=> precharge_current_code == 4'h2
		&& charge_voltage_code == 5'h0B && input_overvoltage_threshold == 2'h1 && input_voltage_limit_code == 4'h6
		&& !watchdog_expired) else $error("register reset left fields");
	a_expiry_single: assert property (watchdog_expired |=> !watchdog_expired)
		else $error("expiry pulse too long");
endmodule // ccr_config_monitor
bind ccr_config_regs ccr_config_monitor #(.SECOND_CYCLES(SECOND_CYCLES)) u_ccr_config_monitor (.*);
`default_nettype wire

// File: ccr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_host_model (
	input wire logic clk_sys,
	input wire logic sda_oe,
	output logic scl_in,
	output logic sda_in
);
	// ****************************************
	// Bus master
	// ****************************************
	// Raising hq slows the bus; SDA only moves while SCL is low, except in start and stop.
	int hq = 6;
	logic sda_h = 1'b1;
	logic scl_h = 1'b1;
	assign scl_in = scl_h;
	assign sda_in = sda_h & !sda_oe;
	task automatic hw();
		repeat (hq) @(negedge clk_sys);
	endtask
	task automatic start();
		sda_h = 1'b1;
		scl_h = 1'b1;
		hw();
		sda_h = 1'b0;
		hw();
		scl_h = 1'b0;
		hw();
	endtask
	task automatic stop();
		sda_h = 1'b0;
		hw();
		scl_h = 1'b1;
		hw();
		sda_h = 1'b1;
		hw();
	endtask
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sda_h = tx[i];
			hw();
			scl_h = 1'b1;
			hw();
			rx[i] = sda_in;
			scl_h = 1'b0;
			hw();
		end
		sda_h = 1'b1;
	endtask
	task automatic write_reg(input logic [7:0] p, input logic [7:0] d, output logic ok);
		logic [8:0] r0, r1, r2;
		start();
		xfer({ccr_pkg::I2C_ADDR, 2'b01}, r0);
		xfer({p, 1'b1}, r1);
		xfer({d, 1'b1}, r2);
		stop();
		ok = !r0[0] && !r1[0] && !r2[0];
	endtask
	task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
		logic [8:0] r;
		start();
		xfer({ccr_pkg::I2C_ADDR, 2'b01}, r);
		xfer({p, 1'b1}, r);
		start();
		xfer({ccr_pkg::I2C_ADDR, 2'b11}, r);
		xfer(9'h1FF, r);
		stop();
		d = r[8:1];
	endtask
endmodule // ccr_host_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin failures++; \
	$display("[ERR] %s exp %0h got %0h", n, e, a); end end
module tb;
	// ****************************************
	// Bench
	// ****************************************
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic ce = 1'b1;
	logic reg_reset = 1'b0;
	logic watchdog_restart_req = 1'b0;
	wire logic scl_in, sda_in, sda_out, sda_oe, watchdog_restart_bit, watchdog_expired;
	wire logic termination_enable, safety_timer_enable, safety_timer_duration;
	wire logic [3:0] precharge_current_code, termination_current_code, input_voltage_limit_code, safety_timer_hours;
	wire logic [4:0] charge_voltage_code;
	wire logic [1:0] topoff_duration, input_overvoltage_threshold;
	wire logic [9:0] precharge_ma, termination_ma;
	wire logic [12:0] charge_mv, input_limit_mv;
	wire logic [5:0] topoff_minutes;
	wire logic [13:0] ovp_mv;
	int failures = 0;
	int n_tests = 0;
	int cyc = 0;
	int n;
	int ovt[4] = '{5500, 6500, 10500, 14000};
	logic [4:0] vc[4] = '{5'h19, 5'h0F, 5'h1F, 5'h00};
	logic [4:0] ec;
	logic [3:0] v;
	logic [1:0] j;
	logic [7:0] rd;
	logic ok;
	always #12.5 clk_sys = ~clk_sys;
	ccr_config_regs #(.SECOND_CYCLES(100)) u_ccr_config_regs (.*);
	ccr_host_model u_ccr_host_model (.*);
	task automatic finish_test();
		if (failures == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// The hang limit sits well above the roughly 35000 cycles the sequence needs.
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 80000) begin
			failures++;
			finish_test();
		end
	end
	task automatic kick();
		watchdog_restart_req = 1'b1;
		@(negedge clk_sys);
		watchdog_restart_req = 1'b0;
		`CHK("restart_bit", 1'b1, watchdog_restart_bit)
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		kick();
		u_ccr_host_model.write_reg(p, d, ok);
		`CHK("ack", 1'b1, ok)
	endtask
	task automatic rdchk(input logic [7:0] p, input logic [7:0] e);
		kick();
		u_ccr_host_model.read_reg(p, rd);
		`CHK("reg read", e, rd)
	endtask
	task automatic chk_defaults();
		rdchk(8'h03, 8'h22);
		rdchk(8'h04, 8'h58);
		rdchk(8'h05, 8'h9F);
		rdchk(8'h06, 8'h66);
		`CHK("charge_mv", 4208, charge_mv)
		`CHK("ovp_mv", 6500, ovp_mv)
		`CHK("input_limit_mv", 4500, input_limit_mv)
		`CHK("sda_out", 1'b0, sda_out)
	endtask
	initial begin
		repeat (2) @(negedge clk_sys);
		rstn = 1'b1;
		repeat (4) @(negedge clk_sys);
		chk_defaults();
		`CHK("precharge_ma", 180, precharge_ma)
		`CHK("hours", 10, safety_timer_hours)
		wr(8'h03, 8'hF5);
		rdchk(8'h03, 8'hC5);
		`CHK("precharge_ma", 780, precharge_ma)
		`CHK("termination_ma", 360, termination_ma)
		for (int i = 0; i < 4; i++) begin
			j = 2'(i);
			ec = (vc[i] > 5'h18) ? 5'h18 : vc[i];
			wr(8'h04, {vc[i], j, 1'b0});
			rdchk(8'h04, {ec, j, 1'b0});
			`CHK("charge_mv", (ec == 5'h0F) ? 4352 : 3856 + 32 * ec, charge_mv)
			`CHK("topoff_minutes", 15 * i, topoff_minutes)
			wr(8'h05, {j[0], 1'b0, j, j[1], j[0], 2'b00});
			rdchk(8'h05, {j[0], 1'b0, j, j[1], j[0], 2'b00});
			`CHK("term_en", j[0], termination_enable)
			`CHK("hours", j[1] ? (j[0] ? 10 : 5) : 0, safety_timer_hours)
			v = (i == 3) ? 4'hF : {2'b00, j};
			wr(8'h06, {j, 2'b01, v});
			rdchk(8'h06, {j, 2'b01, v});
			`CHK("ovp_mv", ovt[i], ovp_mv)
			`CHK("input_limit_mv", 3900 + 100 * v, input_limit_mv)
		end
		// A register reset while the clock enable is low must leave every field alone.
		ce = 1'b0;
		reg_reset = 1'b1;
		@(negedge clk_sys);
		reg_reset = 1'b0;
		ce = 1'b1;
		`CHK("ce_hold", 2'h3, input_overvoltage_threshold)
		wr(8'h07, 8'h55);
		rdchk(8'h07, 8'h00);
		reg_reset = 1'b1;
		@(negedge clk_sys);
		reg_reset = 1'b0;
		chk_defaults();
		wr(8'h03, 8'h55);
		wr(8'h06, 8'h90);
		wr(8'h05, 8'hAF);
		kick();
		n = 1;
		while (watchdog_expired !== 1'b1 && n < 9000) begin
			@(negedge clk_sys);
			n++;
		end
		`CHK("wd_period", 1'b1, n >= 7997 && n <= 8003)
		`CHK("precharge_code", 4'h2, precharge_current_code)
		`CHK("ovp_code", 2'h2, input_overvoltage_threshold)
		rdchk(8'h05, 8'h9F);
		rdchk(8'h06, 8'h90);
		finish_test();
	end
endmodule // tb
`default_nettype wire
